/* bench/decode_model.sv */
`timescale 1ns/1ps
module decode_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // requests from the bench
    input wire logic issue,
    input wire logic [4:0] code_in,
    // instruction port
    input wire logic op_ready,
    output logic op_valid,
    output logic [4:0] op_code
);
    // a released code is inverted so a stale value never looks like an offer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_valid <= 1'b0;
            op_code <= 5'h1f;
        end else if (issue) begin
            op_valid <= 1'b1;
            op_code <= code_in;
        end else if (op_valid && op_ready) begin
            op_valid <= 1'b0;
            op_code <= ~op_code;
        end
    end
endmodule

/* bench/flag_exec_props.sv */
`timescale 1ns/1ps
module flag_exec_props #(
    parameter int WDT_TIMEOUT = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // instruction port
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic op_ready,
    input wire logic op_done,
    // status and power
    input wire logic [7:0] status_byte,
    input wire logic sleeping,
    input wire logic wdt_reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // an apb status write in the same edge may change the other bits
    wire st_wr = psel && penable && pwrite && (paddr == flag_exec_pkg::STATUS_ADDR);
    wire take = op_valid && op_ready;
    property p_rise(logic [4:0] c, int b);
        take && op_code == c && !st_wr
            |=> status_byte == ($past(status_byte) | (8'h01 << b)) && op_done;
    endproperty
    property p_fall(logic [4:0] c, int b);
        take && op_code == c && !st_wr
            |=> status_byte == ($past(status_byte) & ~(8'h01 << b)) && op_done;
    endproperty
    property p_keep(logic [4:0] c);
        take && op_code == c && !st_wr |=> status_byte == $past(status_byte) && op_done;
    endproperty
    sequence s_refuse;
        !op_ready ##1 !op_ready;
    endsequence
    sequence s_finish;
        op_done && (op_ready || sleeping);
    endsequence
    a_ovf_raise: assert property (p_rise(flag_exec_pkg::overflow_raise_op, 3))
        else $error("overflow raise wrong");
    a_ovf_drop: assert property (p_fall(flag_exec_pkg::overflow_drop_op, 3))
        else $error("overflow drop wrong");
    a_sign_raise: assert property (p_rise(flag_exec_pkg::sign_raise_op, 4))
        else $error("sign raise wrong");
    a_sign_drop: assert property (p_fall(flag_exec_pkg::sign_drop_op, 4))
        else $error("sign drop wrong");
    a_half_raise: assert property (p_rise(flag_exec_pkg::half_carry_raise_op, 5))
        else $error("half carry raise wrong");
    a_half_drop: assert property (p_fall(flag_exec_pkg::half_carry_drop_op, 5))
        else $error("half carry drop wrong");
    a_sleep_steps: assert property (take && op_code == flag_exec_pkg::sleep_op
        |=> s_refuse ##1 s_finish) else $error("sleep timing wrong");
    a_sleep_flags: assert property (take && op_code == flag_exec_pkg::sleep_op && !st_wr
        |=> $stable(status_byte)) else $error("sleep changed flags");
    a_wdr_flags: assert property (p_keep(flag_exec_pkg::watchdog_restart_op))
        else $error("watchdog restart changed flags");
    a_wdr_quiet: assert property (take && op_code == flag_exec_pkg::watchdog_restart_op
        |=> !wdt_reset [*8]) else $error("watchdog fired after restart");
    a_carry_raise: assert property (p_rise(flag_exec_pkg::carry_raise_op, 0))
        else $error("carry raise wrong");
    a_nop_keep: assert property (p_keep(flag_exec_pkg::nop_op))
        else $error("no-op changed flags");
    a_illegal_keep: assert property (p_keep(5'h1f))
        else $error("illegal code changed flags");
    a_irq_allow: assert property (p_rise(flag_exec_pkg::irq_global_allow_op, 7))
        else $error("interrupt allow wrong");
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int WDT_T = 16;
    typedef struct {logic [4:0] op; logic [7:0] pre; logic [7:0] exp;} row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue = 1'b0;
    logic [4:0] code_in = 5'h00;
    logic wake_event = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic op_valid, op_ready, op_done, sleeping, wdt_reset, pready, pslverr;
    wire logic [4:0] op_code;
    wire logic [7:0] status_byte;
    wire logic [1:0] sleep_mode;
    wire logic [31:0] prdata;
    int errors = 0;
    int check_count = 0;
    int wdt_seen = 0;
    logic [31:0] rd;
    logic err;
    // raises start clear, drops start full; the last two hit an already settled flag
    row_t rows [20] = '{'{5'h01, 8'h00, 8'h01}, '{5'h02, 8'hff, 8'hfe},
        '{5'h03, 8'h00, 8'h02}, '{5'h04, 8'hff, 8'hfd}, '{5'h05, 8'h00, 8'h04},
        '{5'h06, 8'hff, 8'hfb}, '{5'h07, 8'h00, 8'h08}, '{5'h08, 8'hff, 8'hf7},
        '{5'h09, 8'h00, 8'h10}, '{5'h0a, 8'hff, 8'hef}, '{5'h0b, 8'h00, 8'h40},
        '{5'h0c, 8'hff, 8'hbf}, '{5'h0d, 8'h00, 8'h20}, '{5'h0e, 8'hff, 8'hdf},
        '{5'h0f, 8'h00, 8'h80}, '{5'h10, 8'hff, 8'h7f}, '{5'h00, 8'ha5, 8'ha5},
        '{5'h12, 8'h5a, 8'h5a}, '{5'h07, 8'hff, 8'hff}, '{5'h08, 8'h00, 8'h00}};

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (wdt_reset === 1'b1) wdt_seen++;

    status_flag_exec #(.WDT_TIMEOUT(WDT_T)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready), .op_done(op_done),
        .status_byte(status_byte), .sleeping(sleeping), .sleep_mode(sleep_mode),
        .wake_event(wake_event), .wdt_reset(wdt_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    decode_model u_src (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue),
        .code_in(code_in), .op_ready(op_ready), .op_valid(op_valid), .op_code(op_code));

    task final_report();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task tmo();
        errors++;
        final_report();
    endtask
    task chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task do_op(input logic [4:0] c);
        int i;
        @(posedge ref_clk);
        issue <= 1'b1;
        code_in <= c;
        @(posedge ref_clk);
        issue <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (op_valid === 1'b1 && op_ready === 1'b1) break;
        end
        if (i == 20) tmo();
        #1;
    endtask
    task sleep_test(input logic [31:0] ctrl, input logic s);
        apb(1'b1, flag_exec_pkg::CTRL_ADDR, ctrl);
        apb(1'b1, flag_exec_pkg::STATUS_ADDR, 32'h3c);
        do_op(flag_exec_pkg::sleep_op);
        chk(op_ready, 1'b0);
        @(posedge ref_clk);
        #1;
        chk(op_ready, 1'b0);
        @(posedge ref_clk);
        #1;
        chk(op_done, 1'b1);
        chk(sleeping, s);
        chk(status_byte, 8'h3c);
        chk(op_ready, !s);
        if (s) begin
            chk(sleep_mode, 2'b10);
            @(posedge ref_clk);
            wake_event <= 1'b1;
            @(posedge ref_clk);
            wake_event <= 1'b0;
            #1;
            chk(sleeping, 1'b0);
            chk(op_ready, 1'b1);
        end
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk({op_ready, op_done, sleeping, wdt_reset, status_byte}, 12'h800);
        apb(1'b0, flag_exec_pkg::CTRL_ADDR, 32'h0);
        chk({err, rd}, 33'h0);
        apb(1'b1, 12'h010, 32'hffffffff);
        chk(err, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd}, 33'h100000000);
        apb(1'b0, flag_exec_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        for (int r = 0; r < 20; r++) begin
            apb(1'b1, flag_exec_pkg::STATUS_ADDR, {24'h0, rows[r].pre});
            do_op(rows[r].op);
            chk({op_done, status_byte}, {1'b1, rows[r].exp});
        end
        // two ops taken on consecutive edges
        apb(1'b1, flag_exec_pkg::STATUS_ADDR, 32'h0);
        @(posedge ref_clk);
        issue <= 1'b1;
        code_in <= flag_exec_pkg::overflow_raise_op;
        @(posedge ref_clk);
        code_in <= flag_exec_pkg::sign_raise_op;
        @(posedge ref_clk);
        issue <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({op_done, status_byte}, 9'h118);
        sleep_test(32'h0, 1'b0);
        sleep_test(32'h5, 1'b1);
        apb(1'b1, flag_exec_pkg::CTRL_ADDR, 32'h8);
        repeat (5) begin
            do_op(flag_exec_pkg::watchdog_restart_op);
            repeat (8) @(posedge ref_clk);
        end
        chk(wdt_seen, 0);
        for (int i = 0; i < 40 && wdt_seen == 0; i++) @(posedge ref_clk);
        chk(wdt_seen, 1);
        apb(1'b1, flag_exec_pkg::CTRL_ADDR, 32'h0);
        apb(1'b0, flag_exec_pkg::STATUS_ADDR, 32'h0);
        chk(rd[10], 1'b1);
        apb(1'b1, flag_exec_pkg::STATUS_ADDR, 32'h4ff);
        apb(1'b0, flag_exec_pkg::STATUS_ADDR, 32'h0);
        chk(rd, 32'h0ff);
        do_op(5'h1f);
        chk({op_done, status_byte}, 9'h1ff);
        apb(1'b0, flag_exec_pkg::STATUS_ADDR, 32'h0);
        chk(rd, 32'h2ff);
        apb(1'b0, flag_exec_pkg::RETIRED_ADDR, 32'h0);
        chk(rd, 32'h1e);
        apb(1'b0, flag_exec_pkg::WDT_COUNT_ADDR, 32'h0);
        chk(rd, 32'h0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk({op_ready, status_byte}, 9'h100);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({op_ready, op_done, sleeping, status_byte}, 11'h400);
        final_report();
    end
endmodule

bind status_flag_exec flag_exec_props #(.WDT_TIMEOUT(WDT_TIMEOUT)) u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_ready(op_ready), .op_done(op_done), .status_byte(status_byte),
    .sleeping(sleeping), .wdt_reset(wdt_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr));

/* design/flag_exec_pkg.sv */
package flag_exec_pkg;

    // status byte bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // instruction codes presented by the decode pipeline
    typedef enum logic [4:0] {
        nop_op               = 5'h00,
        carry_raise_op       = 5'h01,
        carry_drop_op        = 5'h02,
        zero_raise_op        = 5'h03,
        zero_drop_op         = 5'h04,
        negative_raise_op    = 5'h05,
        negative_drop_op     = 5'h06,
        overflow_raise_op    = 5'h07,
        overflow_drop_op     = 5'h08,
        sign_raise_op        = 5'h09,
        sign_drop_op         = 5'h0a,
        transfer_bit_raise_op = 5'h0b,
        transfer_bit_drop_op = 5'h0c,
        half_carry_raise_op  = 5'h0d,
        half_carry_drop_op   = 5'h0e,
        irq_global_allow_op  = 5'h0f,
        irq_global_block_op  = 5'h10,
        sleep_op             = 5'h11,
        watchdog_restart_op  = 5'h12
    } op_code_t;

    typedef enum logic [1:0] {
        exec_idle  = 2'b00,
        exec_sleep = 2'b01,
        exec_asleep = 2'b10
    } exec_state_t;

    // timing
    localparam int SINGLE_CYCLES = 1;
    localparam int SLEEP_CYCLES = 3;
    localparam logic [1:0] SLEEP_CNT_LOAD = 2'(SLEEP_CYCLES - 1);
    localparam logic [1:0] SLEEP_CNT_LAST = 2'(SINGLE_CYCLES);
    localparam int WDT_TIMEOUT_DEFAULT = 65536;

    // apb register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] RETIRED_ADDR = 12'h008;
    localparam logic [11:0] WDT_COUNT_ADDR = 12'h00c;

    // ctrl fields
    localparam int CTRL_SLEEP_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_MODE_HI = 2;
    localparam int CTRL_WDT_EN = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status register fields above the status byte
    localparam int STAT_SLEEPING = 8;
    localparam int STAT_ILLEGAL = 9;
    localparam int STAT_WDT_FIRED = 10;

    // position of the flag an instruction touches
    function automatic logic [2:0] flag_index(input op_code_t op);
        case (op)
            carry_raise_op, carry_drop_op: flag_index = 3'(FLAG_C);
            zero_raise_op, zero_drop_op: flag_index = 3'(FLAG_Z);
            negative_raise_op, negative_drop_op: flag_index = 3'(FLAG_N);
            overflow_raise_op, overflow_drop_op: flag_index = 3'(FLAG_V);
            sign_raise_op, sign_drop_op: flag_index = 3'(FLAG_S);
            half_carry_raise_op, half_carry_drop_op: flag_index = 3'(FLAG_H);
            transfer_bit_raise_op, transfer_bit_drop_op: flag_index = 3'(FLAG_T);
            default: flag_index = 3'(FLAG_I);
        endcase
    endfunction

    // true for every code that is one of the flag raise/drop pairs
    function automatic logic is_flag_op(input op_code_t op);
        is_flag_op = (op >= carry_raise_op) && (op <= irq_global_block_op);
    endfunction

endpackage

/* design/flag_update.sv */
`timescale 1ns/1ps
module flag_update (
    // current flags and instruction
    input wire logic [7:0] status_cur,
    input wire logic [4:0] op_code,
    // next flags
    output logic [7:0] status_new,
    output logic illegal
);
    wire flag_exec_pkg::op_code_t op = flag_exec_pkg::op_code_t'(op_code);
    wire flag_op = flag_exec_pkg::is_flag_op(op);
    wire [2:0] idx = flag_exec_pkg::flag_index(op);
    // odd codes raise, even codes drop, the interrupt pair (allow odd, block even) included
    wire raise = (op == flag_exec_pkg::irq_global_allow_op) ? 1'b1 :
                 (op == flag_exec_pkg::irq_global_block_op) ? 1'b0 : op_code[0];
    wire known = (op_code <= 5'(flag_exec_pkg::watchdog_restart_op));

    always_comb begin
        status_new = status_cur;
        if (flag_op) begin
            status_new[idx] = raise; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
        end
    end
    // RULE_09 RULE_10
    assign illegal = ~known;
endmodule

/* design/status_flag_exec.sv */
// Operation
// (RULE_01) The overflow-raise instruction sets the overflow flag to one in one cycle.
// (RULE_02) The overflow-drop instruction clears the overflow flag and keeps every other flag.
// (RULE_03) The sign-raise instruction sets the signed test flag alone, in one cycle.
// (RULE_04) The sign-drop instruction clears the signed test flag alone, in one cycle.
// (RULE_05) The half-carry-raise instruction sets the half carry flag in one cycle.
// (RULE_06) The half-carry-drop instruction clears the half carry flag in one cycle.
// (RULE_07) Sleep takes three cycles, touches no flag and enters the configured low-power mode.
// (RULE_08) Watchdog restart takes one cycle, touches no flag and restarts the watchdog count.
// (RULE_09) Carry, zero, negative, transfer-bit pairs and no-op take one cycle and touch one flag; here the no-op touches no flag.
// (RULE_10) The interrupt allow and block instructions set and clear the enable bit in one cycle.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module status_flag_exec #(
    parameter int WDT_TIMEOUT = flag_exec_pkg::WDT_TIMEOUT_DEFAULT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // instruction issue from decode
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    output logic op_ready,
    output logic op_done,
    // status and power
    output logic [7:0] status_byte,
    output logic sleeping,
    output logic [1:0] sleep_mode,
    input wire logic wake_event,
    // watchdog
    output logic wdt_reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // state
    logic [7:0] status_reg;
    logic [7:0] status_next;
    flag_exec_pkg::exec_state_t state_reg;
    flag_exec_pkg::exec_state_t state_next;
    logic [1:0] sleep_cnt_reg;
    logic [1:0] sleep_cnt_next;
    logic op_ready_reg;
    logic op_ready_next;
    logic op_done_reg;
    logic op_done_next;
    logic sleeping_reg;
    logic [3:0] ctrl_reg;
    logic [3:0] ctrl_next;
    logic illegal_reg;
    logic wdt_fired_reg;
    logic wdt_reset_reg;
    logic [31:0] retired_reg;
    logic [31:0] retired_next;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic sleeping_next;
    logic illegal_next;
    logic wdt_fired_next;
    logic wdt_reset_next;
    logic pready_next;
    logic pslverr_next;

    // instruction decode
    wire take = op_valid & op_ready_reg;
    wire flag_exec_pkg::op_code_t op = flag_exec_pkg::op_code_t'(op_code);
    wire take_sleep = take & (op == flag_exec_pkg::sleep_op);
    wire take_wdr = take & (op == flag_exec_pkg::watchdog_restart_op);
    // an illegal code retires like a no-op so decode never stalls on it
    wire take_single = take & ~take_sleep;
    wire sleep_last = (state_reg == flag_exec_pkg::exec_sleep) &&
                      (sleep_cnt_reg == flag_exec_pkg::SLEEP_CNT_LAST);
    wire sleep_en = ctrl_reg[flag_exec_pkg::CTRL_SLEEP_EN];
    wire wdt_en = ctrl_reg[flag_exec_pkg::CTRL_WDT_EN];

    // flag arithmetic
    wire [7:0] flag_result;
    wire op_illegal;
    wire [31:0] wdt_count;
    wire wdt_expired;

    flag_update u_flag (
        .status_cur(status_reg),
        .op_code(op_code),
        .status_new(flag_result),
        .illegal(op_illegal)
    );

    // the watchdog counts only while enabled, and disabling it clears the count
    wdt_counter #(
        .TIMEOUT(WDT_TIMEOUT)
    ) u_wdt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(wdt_en),
        .restart(take_wdr), // RULE_08
        .count(wdt_count),
        .expired(wdt_expired)
    );

    // apb decode
    // no new setup is seen while the answer stands, so a held psel cannot repeat an access
    wire setup = psel & ~penable & ~pready_reg;
    wire access = psel & penable & pready_reg;
    wire wr = access & pwrite;
    wire hit_ctrl = (paddr == flag_exec_pkg::CTRL_ADDR);
    wire hit_status = (paddr == flag_exec_pkg::STATUS_ADDR);
    wire hit_retired = (paddr == flag_exec_pkg::RETIRED_ADDR);
    wire hit_wdt = (paddr == flag_exec_pkg::WDT_COUNT_ADDR);
    wire hit_any = hit_ctrl | hit_status | hit_retired | hit_wdt;
    wire wr_ctrl = wr & hit_ctrl & ~pslverr_reg;
    wire wr_status = wr & hit_status & ~pslverr_reg;
    wire [31:0] status_word = {21'h000000, wdt_fired_reg, illegal_reg, sleeping_reg, status_reg};
    wire [31:0] ctrl_word = {28'h0000000, ctrl_reg};

    always_comb begin
        prdata_next = prdata_reg;
        if (setup && !pwrite) begin
            prdata_next = 32'h0000_0000;
            if (hit_ctrl) begin
                prdata_next = ctrl_word;
            end
            if (hit_status) begin
                prdata_next = status_word;
            end
            if (hit_retired) begin
                prdata_next = retired_reg;
            end
            if (hit_wdt) begin
                prdata_next = wdt_count;
            end
        end
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata[3:0];
        end
    end

    // status byte: software write lands first, an instruction in the same edge
    // overrides only the flag that it names
    wire [2:0] op_flag = flag_exec_pkg::flag_index(op);
    wire op_is_flag = flag_exec_pkg::is_flag_op(op);

    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = pwdata[7:0];
        end
        // sleep, watchdog restart and no-op leave the flags alone
        if (take_single && op_is_flag) begin
            status_next[op_flag] = flag_result[op_flag]; // RULE_09 RULE_10
        end
    end

    // issue sequencing
    always_comb begin
        state_next = state_reg;
        sleep_cnt_next = sleep_cnt_reg;
        op_ready_next = op_ready_reg;
        op_done_next = take_single;
        case (state_reg)
            flag_exec_pkg::exec_idle: begin
                if (take_sleep) begin
                    // hold issue so the sleep occupies three slots
                    state_next = flag_exec_pkg::exec_sleep; // RULE_07
                    sleep_cnt_next = flag_exec_pkg::SLEEP_CNT_LOAD;
                    op_ready_next = 1'b0;
                end
            end
            flag_exec_pkg::exec_sleep: begin
                sleep_cnt_next = sleep_cnt_reg - 2'h1;
                if (sleep_last) begin
                    op_done_next = 1'b1; // RULE_07
                    if (sleep_en && !wake_event) begin
                        state_next = flag_exec_pkg::exec_asleep;
                    end else begin
                        state_next = flag_exec_pkg::exec_idle;
                        op_ready_next = 1'b1;
                    end
                end
            end
            flag_exec_pkg::exec_asleep: begin
                if (wake_event || wdt_expired) begin
                    state_next = flag_exec_pkg::exec_idle;
                    op_ready_next = 1'b1;
                end
            end
            default: begin
                state_next = flag_exec_pkg::exec_idle;
                op_ready_next = 1'b1;
            end
        endcase
    end

    // counts every completed op, a sleep only when its third cycle ends
    always_comb begin
        retired_next = retired_reg;
        if (op_done_next) begin
            retired_next = retired_reg + 32'h0000_0001;
        end
    end

    assign sleeping_next = (state_next == flag_exec_pkg::exec_asleep); // RULE_07

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_reg <= flag_exec_pkg::STATUS_RESET;
            state_reg <= flag_exec_pkg::exec_idle;
            sleep_cnt_reg <= 2'h0;
            op_ready_reg <= 1'b1;
            op_done_reg <= 1'b0;
            sleeping_reg <= 1'b0;
            ctrl_reg <= flag_exec_pkg::CTRL_RESET;
            retired_reg <= 32'h0000_0000;
        end else begin
            status_reg <= status_next; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
            state_reg <= state_next;
            sleep_cnt_reg <= sleep_cnt_next;
            op_ready_reg <= op_ready_next;
            op_done_reg <= op_done_next;
            sleeping_reg <= sleeping_next; // RULE_07
            ctrl_reg <= ctrl_next;
            retired_reg <= retired_next;
        end
    end

    // sticky events: a new event beats a write-one-to-clear in the same edge
    wire clr_illegal = wr_status & pwdata[flag_exec_pkg::STAT_ILLEGAL];
    wire clr_wdt_fired = wr_status & pwdata[flag_exec_pkg::STAT_WDT_FIRED];
    assign wdt_reset_next = wdt_expired;

    always_comb begin
        illegal_next = illegal_reg;
        if (clr_illegal) begin
            illegal_next = 1'b0;
        end
        if (take && op_illegal) begin
            illegal_next = 1'b1;
        end
    end

    always_comb begin
        wdt_fired_next = wdt_fired_reg;
        if (clr_wdt_fired) begin
            wdt_fired_next = 1'b0;
        end
        if (wdt_expired) begin
            wdt_fired_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            illegal_reg <= 1'b0;
            wdt_fired_reg <= 1'b0;
            wdt_reset_reg <= 1'b0;
        end else begin
            illegal_reg <= illegal_next;
            wdt_fired_reg <= wdt_fired_next;
            wdt_reset_reg <= wdt_reset_next;
        end
    end

    // no wait state: the answer is ready in the first access cycle
    assign pready_next = setup;
    // an unmapped offset answers with an error and its write is dropped
    assign pslverr_next = setup & ~hit_any;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign op_ready = op_ready_reg;
    assign op_done = op_done_reg;
    assign status_byte = status_reg;
    assign sleeping = sleeping_reg;
    assign sleep_mode = ctrl_reg[flag_exec_pkg::CTRL_MODE_HI:flag_exec_pkg::CTRL_MODE_LO];
    assign wdt_reset = wdt_reset_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule

/* design/wdt_counter.sv */
`timescale 1ns/1ps
module wdt_counter #(
    parameter int TIMEOUT = flag_exec_pkg::WDT_TIMEOUT_DEFAULT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic restart,
    // state
    output logic [31:0] count,
    output logic expired
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic expired_reg;
    wire at_end = (count_reg == 32'(TIMEOUT - 1));

    always_comb begin
        count_next = count_reg;
        if (restart || !enable) begin
            count_next = 32'h0000_0000; // RULE_08
        end else if (at_end) begin
            count_next = 32'h0000_0000;
        end else begin
            count_next = count_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_reg <= 32'h0000_0000;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            // a restart in the final cycle still suppresses the timeout
            expired_reg <= enable & at_end & ~restart; // RULE_08
        end
    end

    assign count = count_reg;
    assign expired = expired_reg;
endmodule
